// ### design/lpm_pkg.sv
package lpm_pkg;

  // Machine cycle framing in oscillator periods
  localparam int          MC_CLKS       = 12;
  localparam int          RST_MCYC      = 2;
  localparam logic [3:0]  PH_FIRST      = 4'h0;
  localparam logic [3:0]  PH_LAST       = 4'(MC_CLKS - 1);

  // Reset pin must be held this many oscillator periods
  localparam logic [4:0]  RST_QUAL_CLKS = 5'(MC_CLKS * RST_MCYC);

  // Address latch pulses: two per machine cycle
  localparam logic [3:0]  ALE1_ON       = 4'h0;
  localparam logic [3:0]  ALE2_ON       = 4'h6;
  localparam logic [3:0]  ALE_LEN       = 4'h2;
  localparam logic [3:0]  ADDR_LEN      = 4'h3;

  // Program fetch strobe windows (low active)
  localparam logic [3:0]  PF1_ON        = 4'h3;
  localparam logic [3:0]  PF1_OFF       = 4'h6;
  localparam logic [3:0]  PF2_ON        = 4'h9;

  // External data read and write strobe window
  localparam logic [3:0]  XS_ON         = 4'h3;
  localparam logic [3:0]  XS_OFF        = 4'hB;

  // Highest internal code address
  localparam logic [15:0] INT_CODE_TOP  = 16'h0FFF;

  // Values after reset
  localparam logic [7:0]  PORT_RST      = 8'hFF;

  typedef enum logic [1:0] {
    LPM_RUN   = 2'b00,
    LPM_IDLE  = 2'b01,
    LPM_PDOWN = 2'b10
  } lpm_mode_type;

endpackage

// ### design/lpm_power_pins.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Idle stops the core; RAM, timers, serial port and interrupts keep running.
// - The Idle request instruction is the last one done before Idle.
// - Idle keeps core state, internal RAM and all special registers unchanged.
// - Any enabled interrupt ends Idle; core vectors to its handler and resumes.
// - Hardware reset during Idle ends it and restarts like power-on.
// - Power Down stops the oscillator; its request instruction is the last.
// - Power Down keeps internal RAM and special registers until exit.
// - Only hardware reset leaves Power Down; it resets registers, not RAM.
// - Reset pin high two machine cycles with oscillator running resets device.
// - Idle holds both strobes at 1, Power Down at 0; port 0 floats externally.
// - Port 0 as a general port is open drain; written 1 floats.
// - During external accesses port 0 multiplexes low address and data, strong 1s.
// - Ports 1, 2, 3 written 1 are weakly pulled high and act as inputs.
// - Port 2 drives high address on external fetches and wide pointer moves.
// - Index register moves put the high port latch on port 2.
// - Port 3 bits carry serial, interrupt, timer and data strobe functions.
// - An address latch pulse marks the low address byte of each access.
// - Address latch runs at one sixth oscillator; one pulse skipped per data move.
// - External code: fetch strobe twice per cycle, two skipped per data move.
// - Fetch strobe stays inactive while code comes from internal memory.
// - Fetch select low forces external code; high uses internal up to 0FFFH.
module lpm_power_pins
  import lpm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        reset_pin_i,
  input  wire logic        idle_req_i,
  input  wire logic        pdown_req_i,
  input  wire logic        irq_wake_i,
  input  wire logic        external_fetch_select_i,
  input  wire logic [15:0] pc_i,
  input  wire logic        xmove_req_i,
  input  wire logic        xmove_wide_i,
  input  wire logic        xmove_write_i,
  input  wire logic [15:0] xmove_addr_i,
  input  wire logic [7:0]  xmove_wdata_i,
  input  wire logic [7:0]  p0_latch_i,
  input  wire logic [7:0]  p1_latch_i,
  input  wire logic [7:0]  high_port_latch_i,
  input  wire logic [7:0]  p3_latch_i,
  input  wire logic        serial_out_i,
  input  wire logic [7:0]  p3_pin_i,
  output logic             core_run_o,
  output logic             periph_run_o,
  output logic             osc_run_o,
  output logic             sfr_reset_o,
  output logic             irq_vector_o,
  output logic             ale_o,
  output logic             program_fetch_strobe_n_o,
  output logic [7:0]       p0_o,
  output logic [7:0]       p0_oe_o,
  output logic [7:0]       p1_o,
  output logic [7:0]       p1_oe_o,
  output logic [7:0]       p2_o,
  output logic [7:0]       p2_oe_o,
  output logic [7:0]       p3_o,
  output logic [7:0]       p3_oe_o,
  output logic             serial_in_o,
  output logic             external_irq_zero_o,
  output logic             external_irq_one_o,
  output logic             timer_zero_count_input_o,
  output logic             timer_one_count_input_o
);

  lpm_mode_type mode;
  lpm_mode_type next_mode;
  logic [3:0]   ph;
  logic [4:0]   rst_cnt;
  logic         ext_cyc;
  logic         data_cyc;
  logic         x_wide;
  logic         x_write;
  logic [15:0]  x_addr;
  logic [7:0]   x_wdata;
  logic [15:0]  fetch_addr;

  // Open-drain style general port: drive low only where the latch holds 0
  function automatic logic [7:0] gp_oe(input logic [7:0] latch);
    gp_oe = ~latch;
  endfunction

  // Decoding of mode and phase
  wire run       = (mode == LPM_RUN);
  wire idle      = (mode == LPM_IDLE);
  wire pdown     = (mode == LPM_PDOWN);
  wire rst_hit   = reset_pin_i && (rst_cnt == RST_QUAL_CLKS);
  wire ph_end    = osc_run_o && (ph == PH_LAST);
  wire code_ext  = !external_fetch_select_i || (pc_i > INT_CODE_TOP);
  wire ale1_win  = (ph >= ALE1_ON) && (ph < ALE1_ON + ALE_LEN);
  wire ale2_win  = (ph >= ALE2_ON) && (ph < ALE2_ON + ALE_LEN);
  wire ale_win   = ale1_win || (ale2_win && !data_cyc);
  wire pf_win    = !data_cyc && (((ph >= PF1_ON) && (ph < PF1_OFF)) || (ph >= PF2_ON));
  wire xs_win    = data_cyc && (ph >= XS_ON) && (ph < XS_OFF);
  wire addr_win  = (ph < ADDR_LEN) || (!data_cyc && (ph >= ALE2_ON) && (ph < ALE2_ON + ADDR_LEN));
  wire bus_on    = run && (ext_cyc || data_cyc);
  wire rd_act    = run && xs_win && !x_write;
  wire wr_act    = run && xs_win && x_write;

  // Mode transitions; reset overrides both low power modes
  always_comb begin
    next_mode = mode;
    if (rst_hit) begin
      next_mode = LPM_RUN;
    end else begin
      case (mode)
        LPM_RUN: begin
          if (pdown_req_i) begin
            next_mode = LPM_PDOWN;
          end else if (idle_req_i) begin
            next_mode = LPM_IDLE;
          end
        end
        LPM_IDLE: begin
          if (irq_wake_i) begin
            next_mode = LPM_RUN;
          end
        end
        LPM_PDOWN: next_mode = LPM_PDOWN;
        default:   next_mode = LPM_RUN;
      endcase
    end
  end

  // Strobe levels per mode
  wire next_ale  = idle ? 1'h1 : (pdown ? 1'h0 : ale_win);
  wire next_pf_n = idle ? 1'h1 : (pdown ? 1'h0 : !(ext_cyc && pf_win));

  // Port 0: multiplexed bus, float in low power with external code, else open drain
  wire [7:0] bus_lo  = data_cyc ? x_addr[7:0] : fetch_addr[7:0];
  wire       p0_wr   = data_cyc && x_write && (ph >= XS_ON);
  wire [7:0] next_p0 = bus_on ? (addr_win ? bus_lo : (p0_wr ? x_wdata : 8'h00)) : 8'h00;
  wire [7:0] next_p0_oe = bus_on ? ((addr_win || p0_wr) ? 8'hFF : 8'h00)
                        : (ext_cyc ? 8'h00 : gp_oe(p0_latch_i));

  // Port 2: high address with strong ones, else latch with weak pullups
  wire       p2_addr    = (bus_on && (!data_cyc || x_wide)) || (idle && ext_cyc);
  wire [7:0] next_p2    = p2_addr ? ((data_cyc && run) ? x_addr[15:8] : fetch_addr[15:8]) : 8'h00;
  wire [7:0] next_p2_oe = p2_addr ? 8'hFF : gp_oe(high_port_latch_i);

  // Port 3: serial output and data strobes pull the pin low over the latch
  wire [7:0] p3_eff = p3_latch_i & {!rd_act, !wr_act, 4'hF, serial_out_i, 1'h1};

  // Machine cycle phase; frozen while the oscillator is stopped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ph <= PH_FIRST;
    end else if (osc_run_o) begin
      ph <= ph_end ? PH_FIRST : ph + 4'h1;
    end
  end

  // Reset pin qualification counts only with the oscillator running
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !reset_pin_i) begin
      rst_cnt <= 5'h00;
    end else if (osc_run_o && (rst_cnt != RST_QUAL_CLKS)) begin
      rst_cnt <= rst_cnt + 5'h01;
    end
  end

  // Cycle kind and bus addresses captured at each machine cycle boundary in run mode
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ext_cyc    <= 1'h0;
      data_cyc   <= 1'h0;
      x_wide     <= 1'h0;
      x_write    <= 1'h0;
      x_addr     <= 16'h0000;
      x_wdata    <= 8'h00;
      fetch_addr <= 16'h0000;
    end else if (ph_end && run) begin
      ext_cyc    <= code_ext;
      data_cyc   <= xmove_req_i;
      x_wide     <= xmove_wide_i;
      x_write    <= xmove_write_i;
      x_addr     <= xmove_addr_i;
      x_wdata    <= xmove_wdata_i;
      fetch_addr <= pc_i;
    end
  end

  // Mode and power control outputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode         <= LPM_RUN;
      core_run_o   <= 1'h1;
      periph_run_o <= 1'h1;
      osc_run_o    <= 1'h1;
      sfr_reset_o  <= 1'h1;
      irq_vector_o <= 1'h0;
    end else begin
      mode         <= next_mode;
      core_run_o   <= (next_mode == LPM_RUN);
      periph_run_o <= (next_mode != LPM_PDOWN);
      osc_run_o    <= (next_mode != LPM_PDOWN) || reset_pin_i;
      sfr_reset_o  <= rst_hit;
      irq_vector_o <= idle && irq_wake_i && !rst_hit;
    end
  end

  // Bus strobes and port drivers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ale_o                    <= 1'h0;
      program_fetch_strobe_n_o <= 1'h1;
      p0_o                     <= 8'h00;
      p0_oe_o                  <= 8'h00;
      p1_o                     <= 8'h00;
      p1_oe_o                  <= 8'h00;
      p2_o                     <= 8'h00;
      p2_oe_o                  <= 8'h00;
      p3_o                     <= 8'h00;
      p3_oe_o                  <= 8'h00;
    end else begin
      ale_o                    <= next_ale;
      program_fetch_strobe_n_o <= next_pf_n;
      p0_o                     <= next_p0;
      p0_oe_o                  <= next_p0_oe;
      p1_o                     <= 8'h00;
      p1_oe_o                  <= gp_oe(p1_latch_i);
      p2_o                     <= next_p2;
      p2_oe_o                  <= next_p2_oe;
      p3_o                     <= 8'h00;
      p3_oe_o                  <= gp_oe(p3_eff);
    end
  end

  // Port 3 alternate inputs handed to the peripherals
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      serial_in_o              <= 1'h1;
      external_irq_zero_o      <= 1'h1;
      external_irq_one_o       <= 1'h1;
      timer_zero_count_input_o <= 1'h1;
      timer_one_count_input_o  <= 1'h1;
    end else begin
      serial_in_o              <= p3_pin_i[0];
      external_irq_zero_o      <= p3_pin_i[2];
      external_irq_one_o       <= p3_pin_i[3];
      timer_zero_count_input_o <= p3_pin_i[4];
      timer_one_count_input_o  <= p3_pin_i[5];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_idle_entry;
    run && idle_req_i && !pdown_req_i && !rst_hit;
  endsequence

  sequence s_wake;
    idle && irq_wake_i && !rst_hit;
  endsequence

  AST_IDLE_ENTRY: assert property (s_idle_entry |=> idle && !core_run_o && periph_run_o)
    else $error("idle not entered after request");
  AST_IDLE_WAKE: assert property (s_wake |=> (irq_vector_o && core_run_o) ##1 !irq_vector_o)
    else $error("interrupt did not end idle");
  AST_IDLE_PINS: assert property (idle |=> ale_o && program_fetch_strobe_n_o)
    else $error("strobes not high in idle");
  AST_PD_PINS: assert property (pdown && !reset_pin_i |=> !ale_o && !program_fetch_strobe_n_o
                                && !osc_run_o && pdown)
    else $error("power down pins or oscillator wrong");
  AST_RST_SHORT: assert property (rst_cnt < RST_QUAL_CLKS |=> !sfr_reset_o)
    else $error("reset taken before two machine cycles");
  AST_RST_TAKEN: assert property (rst_hit |=> sfr_reset_o && run && core_run_o)
    else $error("qualified reset not applied");
  AST_INT_CODE: assert property (run && !ext_cyc |=> program_fetch_strobe_n_o)
    else $error("fetch strobe active on internal code");
  AST_DATA_SKIP: assert property (run && data_cyc && (ph == ALE2_ON)
                                  |=> !ale_o && program_fetch_strobe_n_o)
    else $error("pulse not skipped in data move");
  AST_ALE_SECOND: assert property (run && osc_run_o && !data_cyc && (ph == ALE2_ON)
                                   |=> ale_o ##1 ale_o ##1 !ale_o)
    else $error("second latch pulse missing");
  AST_P0_OPEN: assert property (!bus_on && !ext_cyc
                                |=> (p0_o == 8'h00) && (p0_oe_o == ~$past(p0_latch_i)))
    else $error("port 0 not open drain");
  AST_P2_LATCH: assert property (run && data_cyc && !x_wide
                                 |=> p2_oe_o == ~$past(high_port_latch_i))
    else $error("port 2 not showing latch");

  // Data strobes, wide address, the steady state of Idle and the wake vector pulse
  AST_P2_WIDE: assert property (run && data_cyc && x_wide
                                |=> (p2_oe_o == 8'hFF) && (p2_o == $past(x_addr[15:8])))
    else $error("port 2 not driving wide address");
  AST_RD_STROBE: assert property (run && xs_win && !x_write
                                  |=> p3_oe_o[7] && !p3_o[7])
    else $error("read strobe missing in data move");
  AST_WR_STROBE: assert property (run && xs_win && x_write
                                  |=> p3_oe_o[6] && !p3_o[6] && (p0_oe_o == 8'hFF))
    else $error("write strobe or data missing in data move");
  AST_IDLE_HOLD: assert property (idle |-> periph_run_o && !core_run_o)
    else $error("core or peripherals wrong in idle");
  AST_VEC_PULSE: assert property (irq_vector_o |=> !irq_vector_o)
    else $error("interrupt vector longer than one cycle");

endmodule

// ### bench/lpm_ext_mem.sv
`timescale 1ns/1ns
// External program and data memory with its address latch
module lpm_ext_mem (
  input  wire logic        clk_i,
  input  wire logic        ale_i,
  input  wire logic        fetch_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [7:0]  p0_i,
  input  wire logic [7:0]  p2_i,
  output logic             drive_o,
  output logic [7:0]       data_o,
  output logic [15:0]      addr_o,
  output logic [7:0]       wdata_o
);
  logic ale_q;
  // Capture both address bytes as the latch pulse falls, write data while strobe is low
  always_ff @(posedge clk_i) begin
    ale_q <= ale_i;
    if (ale_q && !ale_i) begin
      addr_o <= {p2_i, p0_i};
    end
    if (!wr_n_i) begin
      wdata_o <= p0_i;
    end
  end
  // Answer fetch and read strobes with a pattern of the address
  assign drive_o = !fetch_n_i || !rd_n_i;
  assign data_o  = addr_o[7:0] ^ 8'hA5;
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module testbench;
  import lpm_pkg::*;
  logic clk_i = 0, rst_n_i = 0, reset_pin_i = 0, idle_req_i = 0, pdown_req_i = 0;
  logic irq_wake_i = 0, efs = 1, xmove_req_i = 0, xmove_wide_i = 0, xmove_write_i = 0;
  logic [15:0] pc_i = 16'h0100, xmove_addr_i = 16'h0000;
  logic [7:0]  xmove_wdata_i = 8'h00, p0_latch_i = 8'hFF, p1_latch_i = 8'hFF;
  logic [7:0]  hpl = 8'hFF, p3_latch_i = 8'hFF, p3_pin_i = 8'hFF, p0_last = 8'h00;
  logic core_run_o, periph_run_o, osc_run_o, sfr_reset_o, irq_vector_o, ale_o, fetch_n;
  logic [7:0] p0_o, p0_oe_o, p1_o, p1_oe_o, p2_o, p2_oe_o, p3_o, p3_oe_o, p0_pin, mdata;
  logic serial_in_o, irq0_o, irq1_o, t0_o, t1_o, mdrv;
  logic [15:0] maddr;
  logic [7:0]  mwdata;
  int errors = 0, comparisons = 0, n_ale, n_pf, n_wr, n_rd;
  logic [7:0] p2_seen, p2_pin;
  logic [15:0] a_seen;
  always #5 clk_i = ~clk_i;
  // Port 0 wire: device, then memory, else a floating line shows no stale value
  assign p0_pin = (p0_o & p0_oe_o) | ((mdrv ? mdata : ~p0_last) & ~p0_oe_o);
  always @(posedge clk_i) p0_last <= p0_pin;
  // Port 2 wire: undriven bits pulled high
  assign p2_pin = (p2_o & p2_oe_o) | ~p2_oe_o;
  lpm_power_pins u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reset_pin_i(reset_pin_i),
    .idle_req_i(idle_req_i), .pdown_req_i(pdown_req_i), .irq_wake_i(irq_wake_i),
    .external_fetch_select_i(efs), .pc_i(pc_i), .xmove_req_i(xmove_req_i),
    .xmove_wide_i(xmove_wide_i), .xmove_write_i(xmove_write_i),
    .xmove_addr_i(xmove_addr_i), .xmove_wdata_i(xmove_wdata_i), .p0_latch_i(p0_latch_i),
    .p1_latch_i(p1_latch_i), .high_port_latch_i(hpl), .p3_latch_i(p3_latch_i),
    .serial_out_i(1'b1), .p3_pin_i(p3_pin_i), .core_run_o(core_run_o),
    .periph_run_o(periph_run_o), .osc_run_o(osc_run_o), .sfr_reset_o(sfr_reset_o),
    .irq_vector_o(irq_vector_o), .ale_o(ale_o), .program_fetch_strobe_n_o(fetch_n),
    .p0_o(p0_o), .p0_oe_o(p0_oe_o), .p1_o(p1_o), .p1_oe_o(p1_oe_o), .p2_o(p2_o),
    .p2_oe_o(p2_oe_o), .p3_o(p3_o), .p3_oe_o(p3_oe_o), .serial_in_o(serial_in_o),
    .external_irq_zero_o(irq0_o), .external_irq_one_o(irq1_o),
    .timer_zero_count_input_o(t0_o), .timer_one_count_input_o(t1_o));
  lpm_ext_mem u_mem (.clk_i(clk_i), .ale_i(ale_o), .fetch_n_i(fetch_n),
    .rd_n_i(!(p3_oe_o[7] && !p3_o[7])), .wr_n_i(!(p3_oe_o[6] && !p3_o[6])),
    .p0_i(p0_pin), .p2_i(p2_pin), .drive_o(mdrv), .data_o(mdata), .addr_o(maddr),
    .wdata_o(mwdata));
  // Count strobe activity over n clocks, holding a move request for the first hold
  task automatic count(input int n, input int hold);
    logic a, f;
    n_ale = 0; n_pf = 0; n_wr = 0; n_rd = 0;
    a = ale_o;
    f = fetch_n;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      xmove_req_i = (i < hold);
      if (ale_o && !a) n_ale++;
      if (!fetch_n && f) n_pf++;
      if (p3_oe_o[6] && !p3_o[6]) begin
        n_wr++;
        p2_seen = p2_pin;
        a_seen = maddr;
      end
      if (p3_oe_o[7] && !p3_o[7]) begin
        n_rd++;
        p2_seen = p2_pin;
        a_seen = maddr;
      end
      a = ale_o;
      f = fetch_n;
    end
  endtask
  task automatic wait_clks(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Internal and external code fetch, both ways of selecting external code
  task automatic t_fetch;
    count(48, 0);
    `CHK(n_ale, 8)
    `CHK(n_pf, 0)
    for (int k = 0; k < 2; k++) begin
      efs = k[0];
      pc_i = k[0] ? 16'h12C4 : 16'h0C3B;
      wait_clks(12);
      count(48, 0);
      `CHK(n_pf, 8)
      `CHK(n_ale, 8)
      `CHK(maddr, pc_i)
    end
  endtask
  // Wide write then narrow read, one latch pulse dropped each, two fetch strobes dropped in the write
  task automatic t_moves;
    efs = 0;
    {xmove_wide_i, xmove_write_i, xmove_addr_i, xmove_wdata_i} = {2'b11, 16'h3456, 8'h9C};
    count(48, 12);
    `CHK({n_ale, n_pf, n_wr}, {32'd7, 32'd6, 32'd8})
    `CHK({a_seen, mwdata, p2_seen}, {16'h3456, 8'h9C, 8'h34})
    {xmove_wide_i, xmove_write_i, hpl} = {2'b00, 8'h5A};
    count(48, 12);
    `CHK({n_ale, n_rd, p2_seen}, {32'd7, 32'd8, 8'h5A})
    `CHK(a_seen, 16'h5A56)
  endtask
  // Idle with external code, woken by an interrupt
  task automatic t_idle;
    idle_req_i = 1;
    wait_clks(1);
    idle_req_i = 0;
    wait_clks(13);
    `CHK({core_run_o, periph_run_o, ale_o, fetch_n}, 4'b0111)
    `CHK(p0_oe_o, 8'h00)
    irq_wake_i = 1;
    wait_clks(1);
    irq_wake_i = 0;
    `CHK({irq_vector_o, core_run_o}, 2'b11)
  endtask
  // Short reset pulse ignored, then Power Down left by a qualified reset pin
  task automatic t_pdown;
    reset_pin_i = 1;
    wait_clks(20);
    reset_pin_i = 0;
    wait_clks(2);
    `CHK(sfr_reset_o, 1'b0)
    pdown_req_i = 1;
    wait_clks(1);
    pdown_req_i = 0;
    wait_clks(13);
    `CHK({osc_run_o, core_run_o, periph_run_o, ale_o, fetch_n}, 5'b00000)
    reset_pin_i = 1;
    wait_clks(30);
    `CHK({sfr_reset_o, osc_run_o}, 2'b11)
    reset_pin_i = 0;
    wait_clks(3);
    `CHK({sfr_reset_o, core_run_o}, 2'b01)
  endtask
  // General port directions and port 3 alternate inputs
  task automatic t_ports;
    efs = 1;
    pc_i = 16'h0100;
    p0_latch_i = 8'hF0;
    p1_latch_i = 8'h0F;
    p3_pin_i = 8'hE9;
    wait_clks(14);
    `CHK(p0_oe_o, 8'h0F)
    `CHK(p1_oe_o, 8'hF0)
    `CHK({serial_in_o, irq0_o, irq1_o, t0_o, t1_o}, 5'b10101)
  endtask
  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    wait_clks(8);
    rst_n_i = 1;
    wait_clks(2);
    t_fetch();
    t_moves();
    t_idle();
    t_pdown();
    t_ports();
    stop_test();
  end
endmodule
